// *** rtl/dac_pkg.sv ***
// Purpose: Shared constants and types for the converter digital front end
// Assumes: Single 10 MHz core clock, pins synchronised inside the block
// Notes:   Serial configuration word layout is local to this front end
package dac_pkg;
  localparam int          DATA_W      = 12;
  localparam int          FIFO_DEPTH  = 32;
  localparam int          FRAME_BITS  = 8;
  localparam int          CNT_W       = 4;
  localparam int          CFG_W       = 3;
  localparam int          CFG_TWOS    = 0;
  localparam int          CFG_DIFF    = 1;
  localparam int          CFG_SLEEP   = 2;
  localparam int          READ_BIT    = 7;
  localparam logic [2:0]  CFG_DEFAULT = 3'h0;
  localparam logic [3:0]  FRAME_CNT   = 4'h8;

  typedef enum logic [2:0] {
    SER_IDLE  = 3'b001,
    SER_SHIFT = 3'b010,
    SER_READ  = 3'b100
  } ser_e;
endpackage : dac_pkg

// *** rtl/dac_pin_mode_config.sv ***
// Purpose: Mode selection, pin and serial configuration, sample path
// Assumes: All pins asynchronous to clk; conversion clock well below clk/4
// Notes:   Sample FIFO sits between the capture edge and the output stage
`timescale 1ns/1ps
`default_nettype none

module sample_fifo
  import dac_pkg::*;
#(
  parameter int W = 12,
  parameter int D = 32
)(
  input  wire logic                 clk,       // Core clock
  input  wire logic                 nrst,      // Async reset, active low
  input  wire logic                 in_valid,  // Push request
  output logic                      in_ready,  // Space available
  input  wire logic [W-1:0]         in_data,   // Word pushed
  output logic                      out_valid, // Word available
  input  wire logic                 out_ready, // Pop request
  output logic [W-1:0]              out_data,  // Oldest word
  output logic [$clog2(D+1)-1:0]    count      // Words held
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D+1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } fifo_s;

  fifo_s s_q;
  fifo_s s_d;
  logic  push;
  logic  pop;

  assign in_ready  = (s_q.cnt != CW'(D));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign count     = s_q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = (s_q.wp == AW'(D-1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop)
      s_d.rp = (s_q.rp == AW'(D-1)) ? '0 : s_q.rp + 1'b1;
    s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
endmodule : sample_fifo

////////////////////////////////////////////////////////////////////////////////

// Notes on behaviour
// - Mode select high means pin strapping; low means serial configuration.
// - Mode select pulsed high returns serial configuration to defaults.
// - Pin mode: format pin low straight binary, high twos complement.
// - Pin mode: clock type low single-ended, high differential receiver.
// - Pin mode: sleep pin high powers down, low runs normally.
// - Serial mode: chip select low, serial clock, data pin bidirectional.
// - All ones gives full current on true output, zeros on complement.
module dac_pin_mode_config
  import dac_pkg::*;
(
  input  wire logic              clk,                         // Core clock
  input  wire logic              nrst,                        // Async reset
  input  wire logic              mode_select_reset,           // Pin/serial
  input  wire logic              clock_type_or_serial_clock,  // Type or SCLK
  input  wire logic              sleep_or_chip_select,        // Sleep or CS
  input  wire logic              format_or_serial_data_in,    // Pin level in
  output logic                   format_or_serial_data_out,   // Serial out
  output logic                   format_or_serial_data_oe,    // Drive enable
  input  wire logic              clock_in_pos,                // Conv clock +
  input  wire logic              clock_in_neg,                // Conv clock -
  input  wire logic [DATA_W-1:0] data_in,                     // Host word
  output logic                   data_ready,                  // FIFO space
  output logic [DATA_W-1:0]      true_current_out,            // Code, true
  output logic [DATA_W-1:0]      complement_current_out,      // Code, compl
  output logic                   power_down                   // Sleeping
);
  localparam int CW = $clog2(FIFO_DEPTH+1);

  typedef struct packed {
    logic [1:0]          msr;
    logic [1:0]          sclk;
    logic [1:0]          csn;
    logic [1:0]          sdio;
    logic [1:0]          cpos;
    logic [1:0]          cneg;
    logic [DATA_W-1:0]   dm;
    logic [DATA_W-1:0]   ds;
    logic                conv_prev;
    logic                sclk_prev;
    ser_e                ser;
    logic [CNT_W-1:0]    bits;
    logic [FRAME_BITS-1:0] shift;
    logic [CFG_W-1:0]    cfg;
    logic [CFG_W-1:0]    rd;
    logic                sdo;
    logic                sdo_oe;
    logic [DATA_W-1:0]   iout_t;
    logic [DATA_W-1:0]   iout_c;
    logic                pd;
    logic                rdy;
  } top_s;

  top_s              s_q;
  top_s              s_d;
  logic              pin_mode;
  logic              twos;
  logic              diff;
  logic              sleep;
  logic              conv;
  logic              conv_edge;
  logic              sclk_rise;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              pop;
  logic [DATA_W-1:0] fifo_dout;
  logic [DATA_W-1:0] code;
  logic [CW-1:0]     fifo_count;

  assign pin_mode  = s_q.msr[1];
  assign twos      = pin_mode ? s_q.sdio[1] : s_q.cfg[CFG_TWOS];
  assign diff      = pin_mode ? s_q.sclk[1] : s_q.cfg[CFG_DIFF];
  assign sleep     = pin_mode ? s_q.csn[1]  : s_q.cfg[CFG_SLEEP];
  assign conv      = diff ? (s_q.cpos[1] & ~s_q.cneg[1]) : s_q.cpos[1];
  assign conv_edge = conv & ~s_q.conv_prev;
  assign sclk_rise = s_q.sclk[1] & ~s_q.sclk_prev;
  // Output stage is held at zero and pops nothing while asleep, so the FIFO backs up to the host
  assign pop       = fifo_out_valid && !sleep;
  assign code      = twos ? {~fifo_dout[DATA_W-1], fifo_dout[DATA_W-2:0]}
                          : fifo_dout;

  sample_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (conv_edge),
    .in_ready  (fifo_in_ready),
    .in_data   (s_q.ds),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_dout),
    .count     (fifo_count)
  );

  always_comb
  begin
    s_d           = s_q;
    // First stages feed only the second stages
    s_d.msr       = {s_q.msr[0],  mode_select_reset};
    s_d.sclk      = {s_q.sclk[0], clock_type_or_serial_clock};
    s_d.csn       = {s_q.csn[0],  sleep_or_chip_select};
    s_d.sdio      = {s_q.sdio[0], format_or_serial_data_in};
    s_d.cpos      = {s_q.cpos[0], clock_in_pos};
    s_d.cneg      = {s_q.cneg[0], clock_in_neg};
    s_d.dm        = data_in;
    s_d.ds        = s_q.dm;
    s_d.conv_prev = conv;
    s_d.sclk_prev = s_q.sclk[1];
    s_d.rdy       = fifo_in_ready;
    if (sleep)
    begin
      s_d.iout_t = '0;
      s_d.iout_c = '0;
      s_d.pd     = 1'b1;
    end
    else
    begin
      s_d.pd = 1'b0;
      if (pop)
      begin
        s_d.iout_t = code;
        s_d.iout_c = ~code;
      end
    end
    case (s_q.ser)
      SER_IDLE:
      begin
        s_d.sdo_oe = 1'b0;
        s_d.bits   = '0;
        if (!pin_mode && !s_q.csn[1])
          s_d.ser = SER_SHIFT;
      end
      SER_SHIFT:
      begin
        if (s_q.csn[1])
        begin
          if (s_q.bits == FRAME_CNT && !s_q.shift[READ_BIT])
            s_d.cfg = s_q.shift[CFG_W-1:0];
          s_d.ser = SER_IDLE;
        end
        else if (sclk_rise)
        begin
          s_d.shift = {s_q.shift[FRAME_BITS-2:0], s_q.sdio[1]};
          s_d.bits  = s_q.bits + 1'b1;
          if (s_q.bits == '0 && s_q.sdio[1])
          begin
            s_d.ser = SER_READ;
            s_d.rd  = s_q.cfg;
          end
        end
      end
      SER_READ:
      begin
        s_d.sdo_oe = 1'b1;
        s_d.sdo    = s_q.rd[CFG_W-1];
        if (s_q.csn[1])
        begin
          s_d.sdo_oe = 1'b0;
          s_d.ser    = SER_IDLE;
        end
        else if (sclk_rise)
          s_d.rd = {s_q.rd[CFG_W-2:0], 1'b0};
      end
      default:
      begin
        s_d.ser    = SER_IDLE;
        s_d.sdo_oe = 1'b0;
      end
    endcase
    if (pin_mode)
    begin
      s_d.cfg    = CFG_DEFAULT;
      s_d.ser    = SER_IDLE;
      s_d.sdo_oe = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_q     <= '0;
      s_q.ser <= SER_IDLE;
      s_q.cfg <= CFG_DEFAULT;
    end
    else
      s_q <= s_d;
  end

  assign format_or_serial_data_out = s_q.sdo;
  assign format_or_serial_data_oe  = s_q.sdo_oe;
  assign data_ready                = s_q.rdy;
  assign true_current_out          = s_q.iout_t;
  assign complement_current_out    = s_q.iout_c;
  assign power_down                = s_q.pd;

  ////////////////////////////////////////////////////////////////////////////

  AST_PIN_MODE_QUIET: assert property (
    @(posedge clk) disable iff (!nrst)
    pin_mode |=> (s_q.ser == SER_IDLE) && !format_or_serial_data_oe)
    else $error("serial port active in pin mode");

  AST_CFG_DEFAULT: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(pin_mode) |=> (s_q.cfg == CFG_DEFAULT)[*2])
    else $error("serial config not defaulted");

  AST_TWOS_CODE: assert property (
    @(posedge clk) disable iff (!nrst)
    (pin_mode && s_q.sdio[1] && pop) |=>
      true_current_out == {~$past(fifo_dout[DATA_W-1]),
                           $past(fifo_dout[DATA_W-2:0])})
    else $error("twos complement not offset");

  AST_SE_CLOCK: assert property (
    @(posedge clk) disable iff (!nrst)
    (pin_mode && !s_q.sclk[1] && s_q.cpos[1] && !$past(s_q.cpos[1])
     && !s_q.conv_prev) |-> conv_edge)
    else $error("single ended edge missed");

  AST_SLEEP: assert property (
    @(posedge clk) disable iff (!nrst)
    (pin_mode && s_q.csn[1]) |=> power_down && (true_current_out == '0))
    else $error("sleep not honoured");

  AST_CS_RELEASE: assert property (
    @(posedge clk) disable iff (!nrst)
    (!pin_mode && s_q.csn[1] && s_q.ser != SER_IDLE) |=>
      (s_q.ser == SER_IDLE) ##1 !format_or_serial_data_oe)
    else $error("chip select release ignored");

  AST_FULL_SCALE: assert property (
    @(posedge clk) disable iff (!nrst)
    (pop && code == '1) |=> (true_current_out == '1)
                            && (complement_current_out == '0))
    else $error("full scale not on true output");

  AST_CAPTURE: assert property (
    @(posedge clk) disable iff (!nrst)
    (conv_edge && fifo_in_ready && !pop) |=>
      fifo_count == $past(fifo_count) + 1'b1)
    else $error("edge did not capture word");
endmodule : dac_pin_mode_config

`default_nettype wire

// *** bench/host_model.sv ***
// Purpose: Host data source and serial configuration controller model
// Assumes: Host-driven lines move on a falling clk edge, sdio_in follows the device on rising edges, 100 ns clock
// Notes:   Released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none

module host_model
  import dac_pkg::*;
(
  input  wire logic              clk,      // Core clock
  input  wire logic              sdio_out, // Device serial out
  input  wire logic              sdio_oe,  // Device drives data pin
  output logic                   sdio_in,  // Resolved data pin level
  output logic                   sclk,     // Clock type or serial clock
  output logic                   csn,      // Sleep or chip select
  output logic                   cpos,     // Conversion clock +
  output logic                   cneg,     // Conversion clock -
  output logic [DATA_W-1:0]      word      // Host word
);
  logic host_sdio;
  logic neg_stuck;

  assign sdio_in = sdio_oe ? sdio_out : host_sdio;
  // Minus leg held high hides every edge from a differential receiver
  assign cneg = ~cpos | neg_stuck;

  initial
  begin
    host_sdio = 1'b0;
    neg_stuck = 1'b0;
    sclk = 1'b0;
    csn = 1'b0;
    cpos = 1'b0;
    word = '0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n

  // Only changed while the conversion clock is low, so no false edge
  task automatic stick_neg(input logic v);
    neg_stuck = v;
  endtask : stick_neg

  task automatic pins(input logic fmt, input logic ctype, input logic slp);
    host_sdio = fmt;
    sclk = ctype;
    csn = slp;
    wait_n(4);
  endtask : pins

  task automatic send(input logic [DATA_W-1:0] d);
    word = d;
    wait_n(3);
    cpos = 1'b1;
    wait_n(4);
    cpos = 1'b0;
    word = ~d;
    wait_n(4);
  endtask : send

  task automatic frame(input logic [7:0] w, output logic [7:0] r,
                       output logic oe_seen);
    csn = 1'b0;
    oe_seen = 1'b0;
    wait_n(3);
    for (int i = 7; i >= 0; i--)
    begin
      host_sdio = w[i];
      wait_n(3);
      r[i] = sdio_in;
      oe_seen = oe_seen | sdio_oe;
      sclk = 1'b1;
      wait_n(3);
      sclk = 1'b0;
    end
    host_sdio = ~host_sdio;
    csn = 1'b1;
    wait_n(6);
  endtask : frame
endmodule : host_model

`default_nettype wire

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench for the converter front end
// Assumes: Host model and bench drive all pins on falling clk edges
// Notes:   Words sent asleep fill the FIFO so that one is refused
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import dac_pkg::*;
();
  logic              clk;
  logic              nrst;
  logic              msr;
  logic              sdo;
  logic              soe;
  logic              sdi;
  logic              sclk;
  logic              csn;
  logic              cpos;
  logic              cneg;
  logic [DATA_W-1:0] word;
  logic              rdy;
  logic [DATA_W-1:0] tco;
  logic [DATA_W-1:0] cco;
  logic              pd;
  logic [7:0]        r8;
  logic              oe_seen;
  int                failures;
  int                total_checks;

  dac_pin_mode_config dac_pin_mode_config_i (
    .clk(clk), .nrst(nrst), .mode_select_reset(msr),
    .clock_type_or_serial_clock(sclk), .sleep_or_chip_select(csn),
    .format_or_serial_data_in(sdi), .format_or_serial_data_out(sdo),
    .format_or_serial_data_oe(soe), .clock_in_pos(cpos),
    .clock_in_neg(cneg), .data_in(word), .data_ready(rdy),
    .true_current_out(tco), .complement_current_out(cco),
    .power_down(pd));

  host_model host_model_i (
    .clk(clk), .sdio_out(sdo), .sdio_oe(soe), .sdio_in(sdi),
    .sclk(sclk), .csn(csn), .cpos(cpos), .cneg(cneg), .word(word));

  task automatic check(input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic out_is(input logic [DATA_W-1:0] t);
    check(tco, t);
    check(cco, ~t);
  endtask : out_is

  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Tests need about 800 cycles; 30000 cycles is a hang
  initial
  begin
    #3000000;
    failures++;
    close_out;
  end

  initial
  begin
    failures = 0;
    total_checks = 0;
    nrst = 1'b0;
    msr = 1'b1;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    check(rdy, 1'b1);
    host_model_i.pins(1'b0, 1'b0, 1'b0);
    host_model_i.send(12'hfff);
    out_is(12'hfff);
    host_model_i.send(12'h000);
    out_is(12'h000);
    host_model_i.send(12'ha5c);
    out_is(12'ha5c);
    host_model_i.pins(1'b1, 1'b0, 1'b0);
    host_model_i.send(12'h000);
    out_is(12'h800);
    host_model_i.pins(1'b0, 1'b1, 1'b0);
    host_model_i.send(12'h3c1);
    out_is(12'h3c1);
    // Minus leg held high: only a single-ended receiver sees the edge
    host_model_i.stick_neg(1'b1);
    host_model_i.send(12'h0f0);
    out_is(12'h3c1);
    host_model_i.pins(1'b0, 1'b0, 1'b0);
    host_model_i.send(12'h0f0);
    out_is(12'h0f0);
    host_model_i.stick_neg(1'b0);
    host_model_i.pins(1'b0, 1'b1, 1'b1);
    check(pd, 1'b1);
    check(tco, 12'h000);
    // Asleep nothing drains, so 32 words fill the FIFO and one is refused
    for (int i = 0; i < 32; i++)
      host_model_i.send(12'h100 + DATA_W'(i));
    check(rdy, 1'b0);
    check(tco, 12'h000);
    host_model_i.send(12'h7ff);
    host_model_i.pins(1'b0, 1'b1, 1'b0);
    check(pd, 1'b0);
    host_model_i.wait_n(34);
    out_is(12'h11f);
    check(rdy, 1'b1);
    // Serial mode with chip select idle high
    msr = 1'b0;
    host_model_i.pins(1'b0, 1'b0, 1'b1);
    host_model_i.frame(8'h05, r8, oe_seen);
    check(pd, 1'b1);
    host_model_i.frame(8'h80, r8, oe_seen);
    check(r8[6:4], 3'h5);
    check(oe_seen, 1'b1);
    host_model_i.frame(8'h01, r8, oe_seen);
    check(pd, 1'b0);
    host_model_i.send(12'h000);
    out_is(12'h800);
    // Differential receiver chosen through the serial port
    host_model_i.stick_neg(1'b1);
    host_model_i.frame(8'h03, r8, oe_seen);
    host_model_i.send(12'h123);
    out_is(12'h800);
    host_model_i.stick_neg(1'b0);
    host_model_i.send(12'h123);
    out_is(12'h923);
    msr = 1'b1;
    repeat (5) @(negedge clk);
    msr = 1'b0;
    repeat (5) @(negedge clk);
    host_model_i.send(12'h000);
    out_is(12'h000);
    close_out;
  end
endmodule : tb_top

`default_nettype wire
